/* hdl/tcpfm_pkg.sv */
// constants for the triple channel pulse frequency meter
package tcpfm_pkg;
  localparam int          NUM_POINTS      = 6;
  localparam int          NUM_CHANNELS    = 3;
  localparam int          VAL_W           = 24;
  localparam int          CLK_HZ          = 25000000;
  localparam int          MAX_EDGE_RATE   = 32000;
  localparam int          GATE_TIME_MS    = 20;
  localparam int          GATE_CYCLES     = CLK_HZ / 1000 * GATE_TIME_MS;
  localparam int          MIN_FREQ_MHZ    = 500;
  localparam int          TIMEOUT_CYCLES  = CLK_HZ / MIN_FREQ_MHZ * 1000;
  localparam int          SEC_PER_MIN     = 60;
  // frequency unit is 0.01 Hz: 32 kHz still fits in 24 bits
  localparam int          FREQ_SCALE      = 100;
  localparam logic [7:0]  TEETH_MIN       = 8'h01;
  localparam logic [7:0]  TEETH_RESET     = 8'h3c;
  localparam logic [23:0] FREQ_RESET      = 24'h000000;
  localparam int          REF_PERIOD      = 1000;
  localparam int          REF_HALF        = REF_PERIOD / 2;
  localparam logic [23:0] REF_LOW         = 24'h1e8480;
  localparam logic [23:0] REF_HIGH        = 24'h2dc6c0;

  typedef enum logic [2:0] {
    TCPFM_IDLE = 3'b001,
    TCPFM_SEND = 3'b010,
    TCPFM_DONE = 3'b100
  } tcpfm_xfer_t;

  function automatic logic [23:0] tcpfm_mid3(
    input logic [23:0] a,
    input logic [23:0] b,
    input logic [23:0] c
  );
    logic [23:0] lo;
    logic [23:0] hi;
    lo = (a < b) ? a : b;
    hi = (a < b) ? b : a;
    if (c <= lo)
      tcpfm_mid3 = lo;
    else if (c >= hi)
      tcpfm_mid3 = hi;
    else
      tcpfm_mid3 = c;
  endfunction
endpackage

/* hdl/tcpfm_point.sv */
// one measurement lane: edge counting and period timing for one point
`timescale 1ns/1ps
`default_nettype none
module tcpfm_point
  import tcpfm_pkg::*;
(
  input  wire logic              ref_clk,
  input  wire logic              rst,
  input  wire logic              pulseIn,
  input  wire logic              gateTick,
  output logic [VAL_W-1:0]       freqOut,
  output logic                   freqValid
);
  logic                 pulseDly_reg;
  logic                 edgeSeen;
  logic [VAL_W-1:0]     edgeCnt_reg;
  logic [VAL_W-1:0]     firstEdge_reg;
  logic [VAL_W-1:0]     lastEdge_reg;
  logic [VAL_W-1:0]     timer_reg;
  logic [31:0]          idle_reg;
  logic [47:0]          freq_next;

  // rising edge only; falling edge ignored so ringing on the low side is moot
  assign edgeSeen = pulseIn & ~pulseDly_reg;

  always_ff @(posedge ref_clk or posedge rst)
    if (rst)
      pulseDly_reg <= 1'b0;
    else
      pulseDly_reg <= pulseIn;

  // one edge per clock max: 25 MHz clock far exceeds 32 k edges per second
  always_ff @(posedge ref_clk or posedge rst)
    if (rst)
    begin
      edgeCnt_reg   <= '0;
      firstEdge_reg <= '0;
      lastEdge_reg  <= '0;
      timer_reg     <= '0;
    end
    else if (gateTick)
    begin
      edgeCnt_reg   <= {{(VAL_W-1){1'b0}}, edgeSeen};
      firstEdge_reg <= '0;
      lastEdge_reg  <= '0;
      timer_reg     <= '0;
    end
    else
    begin
      timer_reg <= timer_reg + 1'b1;
      if (edgeSeen)
      begin
        if (edgeCnt_reg == '0)
          firstEdge_reg <= timer_reg;
        lastEdge_reg <= timer_reg;
        edgeCnt_reg  <= edgeCnt_reg + 1'b1;
      end
    end

  always_ff @(posedge ref_clk or posedge rst)
    if (rst)
      idle_reg <= '0;
    else if (edgeSeen)
      idle_reg <= '0;
    else if (idle_reg < TIMEOUT_CYCLES)
      idle_reg <= idle_reg + 1'b1;

  // frequency in 0.01 Hz = (edges-1) * clk * scale / span of edge times
  always_comb
  begin
    freq_next = '0;
    if (edgeCnt_reg > 1 && lastEdge_reg != firstEdge_reg)
      freq_next = (48'(edgeCnt_reg - 1'b1) * 48'(CLK_HZ)
                   * 48'(FREQ_SCALE))
                  / 48'(lastEdge_reg - firstEdge_reg);
  end

  always_ff @(posedge ref_clk or posedge rst)
    if (rst)
    begin
      freqOut   <= FREQ_RESET;
      freqValid <= 1'b0;
    end
    else
    begin
      freqValid <= gateTick;
      if (gateTick)
      begin
        if (idle_reg >= TIMEOUT_CYCLES)
          freqOut <= FREQ_RESET;
        else if (freq_next != '0)
          freqOut <= freq_next[VAL_W-1:0];
      end
    end
endmodule // tcpfm_point
`default_nettype wire

/* hdl/tcpfm_top.sv */
// triple channel pulse frequency meter: three channels, mid-value, diagnostics
// Functional notes
// - Each pulse is counted once, on its rising edge only.
// - Counters keep up with more than 32,000 edges per second.
// - Each of three channels turns every point's pulses into frequency.
// - A channel sends values only when its main processor requests.
// - Per scan the three channel values are reduced by mid-value pick.
// - Channels share only the gate timer and reference generator, so a lane fault stays local.
// - Diagnostics run per channel; a fault lights fault and alarm.
// - One faulty channel does not corrupt the selected measurement.
// - A hot-spare input lets the module run as backup or take over.
// - Six points are measured separately.
// - Gear teeth per point are set from 1 to 255.
// - Every point is updated at least every 20 ms.
// - Tracking follows 4,000 RPM per second at 60 teeth.
// - Frequency comes from counted edges over measured elapsed time.
`timescale 1ns/1ps
`default_nettype none
module tcpfm_top
  import tcpfm_pkg::*;
(
  input  wire logic                          ref_clk,
  input  wire logic                          rst,
  input  wire logic [NUM_CHANNELS*NUM_POINTS-1:0] pulseIn,
  input  wire logic [NUM_POINTS*8-1:0]       gearTeeth,
  input  wire logic [NUM_CHANNELS-1:0]       readReq,
  input  wire logic                          spareMode,
  input  wire logic                          takeOver,
  output logic [NUM_CHANNELS-1:0]            readBusy,
  output logic [NUM_CHANNELS-1:0]            wordValid,
  output logic [NUM_CHANNELS*VAL_W-1:0]      wordData,
  output logic [NUM_CHANNELS*3-1:0]          wordIndex,
  output logic [NUM_POINTS*VAL_W-1:0]        selFreq,
  output logic [NUM_POINTS*VAL_W-1:0]        selRpm,
  output logic                               scanTick,
  output logic [NUM_CHANNELS-1:0]            chanFault,
  output logic                               faultLed,
  output logic                               sysAlarm,
  output logic                               moduleActive
);
  logic [31:0]              gate_reg;
  logic                     gateTick;
  logic [9:0]               refCnt_reg;
  logic                     refPulse;
  logic [VAL_W-1:0]         freq   [NUM_CHANNELS][NUM_POINTS];
  logic [VAL_W-1:0]         refFreq[NUM_CHANNELS];
  logic [NUM_CHANNELS-1:0]  refValid;
  logic [NUM_POINTS-1:0]    ptValid;
  logic [VAL_W-1:0]         mid    [NUM_POINTS];
  logic                     active_reg;

  // one gate window of 20 ms; all lanes close their window together
  always_ff @(posedge ref_clk or posedge rst)
    if (rst)
      gate_reg <= '0;
    else if (gate_reg == GATE_CYCLES - 1)
      gate_reg <= '0;
    else
      gate_reg <= gate_reg + 1'b1;
  assign gateTick = (gate_reg == GATE_CYCLES - 1);

  // internal precision reference at 25 kHz feeds a spare lane per channel
  always_ff @(posedge ref_clk or posedge rst)
    if (rst)
      refCnt_reg <= '0;
    else if (refCnt_reg == 10'(REF_PERIOD - 1))
      refCnt_reg <= '0;
    else
      refCnt_reg <= refCnt_reg + 1'b1;
  assign refPulse = (refCnt_reg < 10'(REF_HALF));

  // each channel owns its own lanes: no shared sensing state across channels
  for (genvar c = 0; c < NUM_CHANNELS; c++)
  begin : g_chan
    for (genvar p = 0; p < NUM_POINTS; p++)
    begin : g_pt
      tcpfm_point u_pt (
        .ref_clk   (ref_clk),
        .rst       (rst),
        .pulseIn   (pulseIn[c*NUM_POINTS+p]),
        .gateTick  (gateTick),
        .freqOut   (freq[c][p]),
        .freqValid ()
      );
    end
    tcpfm_point u_ref (
      .ref_clk   (ref_clk),
      .rst       (rst),
      .pulseIn   (refPulse),
      .gateTick  (gateTick),
      .freqOut   (refFreq[c]),
      .freqValid (refValid[c])
    );

    // diagnostic: reference must read inside its window; sticky until reset
    always_ff @(posedge ref_clk or posedge rst)
      if (rst)
        chanFault[c] <= 1'b0;
      else if (refValid[c] &&
               (refFreq[c] < REF_LOW || refFreq[c] > REF_HIGH))
        chanFault[c] <= 1'b1;
  end

  assign faultLed = |chanFault;
  assign sysAlarm = faultLed;

  // hot spare: waits in backup until told to take over, then stays active
  always_ff @(posedge ref_clk or posedge rst)
    if (rst)
      active_reg <= 1'b0;
    else if (!spareMode || takeOver)
      active_reg <= 1'b1;
  assign moduleActive = active_reg;

  // mid-value pick masks any one wrong channel
  for (genvar p = 0; p < NUM_POINTS; p++)
  begin : g_vote
    logic [31:0] teeth32;
    logic [55:0] rpmWide;
    assign mid[p] = tcpfm_mid3(freq[0][p], freq[1][p],
                               freq[2][p]);
    // teeth of zero is out of range; treated as one to avoid divide by zero
    assign teeth32 = (gearTeeth[p*8 +: 8] < TEETH_MIN) ? 32'(TEETH_MIN)
                     : 32'(gearTeeth[p*8 +: 8]);
    // freq is in 0.01 Hz, so divide by the scale for whole rpm
    assign rpmWide = 56'(mid[p]) * 56'(SEC_PER_MIN)
                     / (56'(teeth32) * 56'(FREQ_SCALE));
    always_ff @(posedge ref_clk or posedge rst)
      if (rst)
      begin
        selFreq[p*VAL_W +: VAL_W] <= FREQ_RESET;
        selRpm[p*VAL_W +: VAL_W]  <= FREQ_RESET;
      end
      else if (ptValid[p])
      begin
        selFreq[p*VAL_W +: VAL_W] <= mid[p];
        selRpm[p*VAL_W +: VAL_W]  <= rpmWide[VAL_W-1:0];
      end
  end
  assign ptValid = {NUM_POINTS{refValid[0]}};

  always_ff @(posedge ref_clk or posedge rst)
    if (rst)
      scanTick <= 1'b0;
    else
      scanTick <= refValid[0];

  // per-channel reply: on request, stream six words, one per clock
  for (genvar c = 0; c < NUM_CHANNELS; c++)
  begin : g_xfer
    tcpfm_xfer_t state_reg;
    logic [2:0]  idx_reg;
    always_ff @(posedge ref_clk or posedge rst)
      if (rst)
      begin
        state_reg <= TCPFM_IDLE;
        idx_reg   <= '0;
      end
      else
        unique case (state_reg)
          TCPFM_IDLE:
            if (readReq[c] && active_reg)
            begin
              state_reg <= TCPFM_SEND;
              idx_reg   <= '0;
            end
          TCPFM_SEND:
            if (idx_reg == 3'(NUM_POINTS - 1))
              state_reg <= TCPFM_DONE;
            else
              idx_reg <= idx_reg + 1'b1;
          TCPFM_DONE:
            if (!readReq[c])
              state_reg <= TCPFM_IDLE;
          default:
            state_reg <= TCPFM_IDLE;
        endcase

    always_ff @(posedge ref_clk or posedge rst)
      if (rst)
      begin
        wordValid[c]         <= 1'b0;
        wordData[c*VAL_W +: VAL_W] <= '0;
        wordIndex[c*3 +: 3]  <= '0;
      end
      else
      begin
        wordValid[c] <= (state_reg == TCPFM_SEND);
        wordData[c*VAL_W +: VAL_W] <= freq[c][idx_reg];
        wordIndex[c*3 +: 3] <= idx_reg;
      end
    assign readBusy[c] = (state_reg != TCPFM_IDLE);
  end
endmodule // tcpfm_top
`default_nettype wire

/* verification/tcpfm_props.sv */
// port assertions for the pulse meter top
`timescale 1ns/1ps
`default_nettype none
module tcpfm_props
  import tcpfm_pkg::*;
(
  input wire logic                      ref_clk,
  input wire logic                      rst,
  input wire logic [NUM_CHANNELS-1:0]   readReq,
  input wire logic                      spareMode,
  input wire logic                      takeOver,
  input wire logic [NUM_CHANNELS-1:0]   readBusy,
  input wire logic [NUM_CHANNELS-1:0]   wordValid,
  input wire logic [NUM_CHANNELS*3-1:0] wordIndex,
  input wire logic                      scanTick,
  input wire logic [NUM_CHANNELS-1:0]   chanFault,
  input wire logic                      faultLed,
  input wire logic                      sysAlarm,
  input wire logic                      moduleActive
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  property p_take_req;
    readReq[0] && moduleActive && !readBusy[0] |=> readBusy[0];
  endproperty
  a_take_req: assert property (p_take_req)
    else $error("request not taken");
  property p_word_in_xfer;
    wordValid[1] |-> readBusy[1];
  endproperty
  a_word_in_xfer: assert property (p_word_in_xfer)
    else $error("word outside a transfer");
  property p_six_words;
    $rose(wordValid[0]) |-> wordValid[0] [*6] ##1 !wordValid[0];
  endproperty
  a_six_words: assert property (p_six_words)
    else $error("word burst length wrong");
  property p_index_order;
    wordValid[0] |-> wordIndex[2:0] ==
      ($rose(wordValid[0]) ? 3'h0 : $past(wordIndex[2:0]) + 3'h1);
  endproperty
  a_index_order: assert property (p_index_order)
    else $error("word index out of order");
  property p_spare_quiet;
    !moduleActive && !readBusy[2] |=> !readBusy[2];
  endproperty
  a_spare_quiet: assert property (p_spare_quiet)
    else $error("inactive module answered");
  property p_take_over;
    takeOver |=> moduleActive;
  endproperty
  a_take_over: assert property (p_take_over)
    else $error("take-over ignored");
  property p_alarm;
    faultLed == (|chanFault) && sysAlarm == faultLed;
  endproperty
  a_alarm: assert property (p_alarm)
    else $error("fault indicator or alarm wrong");
  property p_fault_sticky;
    chanFault[0] |=> chanFault[0];
  endproperty
  a_fault_sticky: assert property (p_fault_sticky)
    else $error("channel fault cleared");
  property p_scan_pulse;
    scanTick |=> !scanTick;
  endproperty
  a_scan_pulse: assert property (p_scan_pulse)
    else $error("scan tick too long");
endmodule // tcpfm_props

bind tcpfm_top tcpfm_props u_props (.ref_clk(ref_clk), .rst(rst),
  .readReq(readReq), .spareMode(spareMode), .takeOver(takeOver),
  .readBusy(readBusy), .wordValid(wordValid), .wordIndex(wordIndex),
  .scanTick(scanTick), .chanFault(chanFault), .faultLed(faultLed),
  .sysAlarm(sysAlarm), .moduleActive(moduleActive));
`default_nettype wire

/* verification/tcpfm_mp_model.sv */
// main processor model: requests one channel's words and counts them
`timescale 1ns/1ps
`default_nettype none
module tcpfm_mp_model
(
  input  wire logic       ref_clk,
  input  wire logic       rst,
  input  wire logic       start,
  input  wire logic       wordValid,
  input  wire logic [2:0] wordIndex,
  output logic            readReq,
  output logic [3:0]      wordCnt,
  output logic            idxErr
);
  // request held until all six words are in, as the device expects
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      readReq <= 1'b0;
      wordCnt <= 4'h0;
      idxErr  <= 1'b0;
    end
    else if (!start)
    begin
      readReq <= 1'b0;
      wordCnt <= 4'h0;
    end
    else if (wordValid)
    begin
      wordCnt <= wordCnt + 4'h1;
      if (wordIndex !== wordCnt[2:0])
        idxErr <= 1'b1;
    end
    else
      readReq <= (wordCnt != 4'h6);
  end
endmodule // tcpfm_mp_model
`default_nettype wire

/* verification/tb_top.sv */
// self-checking bench for the pulse meter top
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, exp, got) begin checked++; if ((got) !== (exp)) begin \
  errorCnt++; $display("MISMATCH %s exp %0h got %0h", nm, exp, got); end end
module tb_top
  import tcpfm_pkg::*;
;
  logic        ref_clk = 1'b0;
  logic        rst = 1'b1;
  logic [17:0] pulseIn = 18'h00000;
  logic [47:0] gearTeeth = {6{TEETH_RESET}};
  logic [2:0]  start = 3'h0;
  logic        spareMode = 1'b0;
  logic        takeOver = 1'b0;
  logic [9:0]  div = 10'h000;
  wire  [2:0]  readReq;
  logic [2:0]  readBusy, wordValid, chanFault;
  logic [8:0]  wordIndex;
  logic        scanTick, faultLed, sysAlarm, moduleActive;
  wire  [3:0]  wordCnt [3];
  wire         idxErr [3];
  int          errorCnt = 0;
  int          checked = 0;

  initial forever #20 ref_clk = ~ref_clk;
  // rising edges every 1024 cycles, inside the measurable range
  always @(posedge ref_clk)
  begin
    div <= div + 10'h001;
    pulseIn <= {18{div[9]}};
  end

  tcpfm_top dut (.ref_clk(ref_clk), .rst(rst), .pulseIn(pulseIn),
    .gearTeeth(gearTeeth), .readReq(readReq), .spareMode(spareMode),
    .takeOver(takeOver), .readBusy(readBusy), .wordValid(wordValid),
    .wordData(), .wordIndex(wordIndex), .selFreq(), .selRpm(),
    .scanTick(scanTick), .chanFault(chanFault), .faultLed(faultLed),
    .sysAlarm(sysAlarm), .moduleActive(moduleActive));

  for (genvar c = 0; c < 3; c++)
  begin : g_mp
    tcpfm_mp_model mp (.ref_clk(ref_clk), .rst(rst), .start(start[c]),
      .wordValid(wordValid[c]), .wordIndex(wordIndex[c*3+:3]),
      .readReq(readReq[c]), .wordCnt(wordCnt[c]), .idxErr(idxErr[c]));
  end

  task automatic final_report();
    $display("checks %0d mismatches %0d", checked, errorCnt);
    if (errorCnt == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic doReset(input logic spare);
    rst <= 1'b1;
    spareMode <= spare;
    repeat (6) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (2) @(posedge ref_clk);
  endtask

  // the transfer walk is fixed at six SEND cycles, so a fixed wait is enough
  task automatic readAll(input logic [2:0] mask, input logic [3:0] n);
    start <= mask;
    repeat (14) @(posedge ref_clk);
    for (int c = 0; c < 3; c++)
    begin
      `CHK("word count", mask[c] ? n : 4'h0, wordCnt[c])
      `CHK("index error", 1'b0, idxErr[c])
    end
    start <= 3'h0;
    repeat (3) @(posedge ref_clk);
    `CHK("busy after drop", 3'h0, readBusy)
  endtask

  task automatic testReset();
    doReset(1'b0);
    `CHK("active", 1'b1, moduleActive)
    `CHK("fault", 3'h0, chanFault)
    `CHK("led", 1'b0, faultLed)
    `CHK("alarm", 1'b0, sysAlarm)
    $display("test reset done");
  endtask

  task automatic testRead();
    readAll(3'h7, 4'h6);
    readAll(3'h2, 4'h6);
    readAll(3'h5, 4'h6);
    $display("test read done");
  endtask

  task automatic testSpare();
    doReset(1'b1);
    `CHK("spare idle", 1'b0, moduleActive)
    readAll(3'h1, 4'h0);
    takeOver <= 1'b1;
    @(posedge ref_clk);
    takeOver <= 1'b0;
    repeat (2) @(posedge ref_clk);
    `CHK("taken over", 1'b1, moduleActive)
    readAll(3'h1, 4'h6);
    $display("test spare done");
  endtask

  initial
  begin
    repeat (3000) @(posedge ref_clk);
    errorCnt++;
    final_report();
  end

  initial
  begin
    testReset();
    testRead();
    testSpare();
    final_report();
  end
endmodule // tb_top
`default_nettype wire
